// ### mbag_regs.svh
`ifndef MBAG_REGS_SVH
`define MBAG_REGS_SVH

// register byte offsets on the apb bus
`define MBAG_AW         8
`define MBAG_OFS_AMC    8'h00
`define MBAG_OFS_BRC    8'h04
`define MBAG_OFS_TPG    8'h08
`define MBAG_OFS_VPG    8'h0c
`define MBAG_OFS_XBS    8'h10
`define MBAG_OFS_XBE    8'h14
`define MBAG_OFS_YBS    8'h18
`define MBAG_OFS_YBE    8'h1c
`define MBAG_OFS_CCR    8'h20
`define MBAG_OFS_STA    8'h24

// field positions
`define MBAG_F_XSEL     3:0
`define MBAG_F_YSEL     7:4
`define MBAG_F_BSEL     11:8
`define MBAG_F_XMEN     15
`define MBAG_F_YMEN     14
`define MBAG_F_BRVEN    15
`define MBAG_F_BMOD     14:0
`define MBAG_F_CFGSP    7
`define MBAG_F_WINEN    2
`define MBAG_F_EATOP    15
`define MBAG_F_VPG0     0

// selector value that means "no pointer"
`define MBAG_SEL_OFF    4'hf

// reset values
`define MBAG_RST_AMC    16'h0fff
`define MBAG_RST_16     16'h0000
`define MBAG_RST_8      8'h00

`endif

// ### mbag_pkg.sv
package mbag_pkg;

	// addressing mode of one effective-address request, one-hot
	typedef enum logic [5:0] {
		am_ind      = 6'h01,
		am_post_inc = 6'h02,
		am_post_dec = 6'h04,
		am_pre_inc  = 6'h08,
		am_pre_dec  = 6'h10,
		am_reg_ofs  = 6'h20
	} mbag_amode_t;

	// request from operand fetch to one address generator
	typedef struct packed {
		logic        valid;
		logic [3:0]  wsel;
		logic [15:0] wval;
		mbag_amode_t mode;
		logic [15:0] ofs;
		logic        byte_acc;
	} mbag_agu_req_t;

	// answer of one address generator
	typedef struct packed {
		logic        valid;
		logic [15:0] ea;
		logic        wb_en;
		logic [15:0] wb_val;
		logic        wrapped;
		logic        brev;
	} mbag_agu_rsp_t;

	// data-space access that may fall in the program window
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] ea;
	} mbag_win_req_t;

	// program-space address with its space flag
	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
		logic        cfg;
	} mbag_prog_addr_t;

endpackage : mbag_pkg

// ### mbag_modulo.sv
`timescale 1ns/10ps

// circular buffer boundary check and wrap for one generator
module mbag_modulo #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] addr,
	input  wire logic         up,
	input  wire logic         on,
	input  wire logic [W-1:0] buf_start,
	input  wire logic [W-1:0] buf_end,
	output logic      [W-1:0] out_addr,
	output logic              wrap
);

	logic [W:0]   buf_len;
	logic         beyond;
	logic [W-1:0] wrapped_addr;

	// length is implied by the two limits, end is the last byte
	assign buf_len      = {1'b0, buf_end} - {1'b0, buf_start} + {{W{1'b0}}, 1'b1};
	// upward buffers watch the end, downward ones the start
	// only a step past the limit counts, not landing on it
	assign beyond       = up ? (addr > buf_end) : (addr < buf_start);
	// wrap by one length back into the buffer
	assign wrapped_addr = up ? (addr - buf_len[W-1:0]) : (addr + buf_len[W-1:0]);
	assign wrap         = on & beyond;
	assign out_addr     = wrap ? wrapped_addr : addr;

endmodule : mbag_modulo

// ### mbag_top.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "mbag_regs.svh"

module mbag_top
	import mbag_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [`MBAG_AW-1:0]    paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire mbag_agu_req_t [2:0]    agu_req,
	output mbag_agu_rsp_t [2:0]         agu_rsp,
	input  wire logic                   tbl_valid,
	input  wire logic [15:0]            tbl_ea,
	output mbag_prog_addr_t             tbl_addr,
	input  wire mbag_win_req_t          win_req,
	output mbag_prog_addr_t             win_addr,
	output logic                        win_wr_refused,
	input  wire logic                   prog_rvalid,
	input  wire logic [23:0]            prog_rdata,
	output logic                        win_rvalid,
	output logic [15:0]                 win_rdata
);

	localparam int NCH   = 3;
	localparam int CH_XR = 0;
	localparam int CH_XW = 1;
	localparam int CH_Y  = 2;

	// software-visible registers
	logic [15:0] amc_q;
	logic [15:0] brc_q;
	logic [7:0]  tpg_q;
	logic [7:0]  vpg_q;
	logic [15:0] xbs_q;
	logic [15:0] xbe_q;
	logic [15:0] ybs_q;
	logic [15:0] ybe_q;
	logic [15:0] ccr_q;

	// apb outputs
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	// generator and program-space outputs
	mbag_agu_rsp_t [2:0] agu_rsp_q;
	mbag_agu_rsp_t [2:0] agu_rsp_d;
	mbag_prog_addr_t     tbl_addr_q;
	mbag_prog_addr_t     tbl_addr_d;
	mbag_prog_addr_t     win_addr_q;
	mbag_prog_addr_t     win_addr_d;
	logic                win_wr_refused_q;
	logic                win_rvalid_q;
	logic [15:0]         win_rdata_q;

	// reverse-carry add: reverse both, add normally, reverse back, so
	// carries ripple from the msb down toward the lsb
	function automatic logic [15:0] mbag_rev_add(
		input logic [15:0] a,
		input logic [15:0] b
	);
		logic [15:0] ra;
		logic [15:0] rb;
		logic [15:0] rs;
		logic [15:0] res;
		ra  = '0;
		rb  = '0;
		res = '0;
		for (int i = 0; i < 16; i++) begin
			ra[i] = a[15-i];
			rb[i] = b[15-i];
		end
		rs = ra + rb;
		for (int i = 0; i < 16; i++) begin
			res[i] = rs[15-i];
		end
		return res;
	endfunction : mbag_rev_add

	// ---------------- apb slave ----------------
	wire         apb_setup  = psel & ~penable;
	wire         apb_done   = psel & penable & pready_q;
	wire         apb_wr     = apb_done & pwrite;
	wire         hit_amc    = (paddr == `MBAG_OFS_AMC);
	wire         hit_brc    = (paddr == `MBAG_OFS_BRC);
	wire         hit_tpg    = (paddr == `MBAG_OFS_TPG);
	wire         hit_vpg    = (paddr == `MBAG_OFS_VPG);
	wire         hit_xbs    = (paddr == `MBAG_OFS_XBS);
	wire         hit_xbe    = (paddr == `MBAG_OFS_XBE);
	wire         hit_ybs    = (paddr == `MBAG_OFS_YBS);
	wire         hit_ybe    = (paddr == `MBAG_OFS_YBE);
	wire         hit_ccr    = (paddr == `MBAG_OFS_CCR);
	wire         hit_sta    = (paddr == `MBAG_OFS_STA);
	wire         hit_any    = hit_amc | hit_brc | hit_tpg | hit_vpg | hit_xbs | hit_xbe |
	                          hit_ybs | hit_ybe | hit_ccr | hit_sta;
	// the status word is read only, so a write to it is an error too
	wire         bad_access = ~hit_any | (hit_sta & pwrite);

	// mode decode from the control registers
	wire [3:0]   x_msel     = amc_q[`MBAG_F_XSEL];
	wire [3:0]   y_msel     = amc_q[`MBAG_F_YSEL];
	wire [3:0]   b_sel      = amc_q[`MBAG_F_BSEL];
	wire         x_mod_en   = amc_q[`MBAG_F_XMEN] & (x_msel != `MBAG_SEL_OFF);
	wire         y_mod_en   = amc_q[`MBAG_F_YMEN] & (y_msel != `MBAG_SEL_OFF);
	wire         brev_en    = brc_q[`MBAG_F_BRVEN] & (b_sel != `MBAG_SEL_OFF);
	// pivot scaled from words to bytes, so bit 0 stays clear
	wire [15:0]  brev_mod   = {brc_q[`MBAG_F_BMOD], 1'b0};
	wire         win_en     = ccr_q[`MBAG_F_WINEN];

	logic [2:0]  wrap_w;
	logic        brev_used;
	wire  [15:0] status_w   = {9'h000, wrap_w, brev_used, y_mod_en, x_mod_en, brev_en};

	// read mux, registered in the setup cycle
	wire  [31:0] rd_mux     =
		hit_amc ? {16'h0000, amc_q} :
		hit_brc ? {16'h0000, brc_q} :
		hit_tpg ? {24'h000000, tpg_q} :
		hit_vpg ? {24'h000000, vpg_q} :
		hit_xbs ? {16'h0000, xbs_q} :
		hit_xbe ? {16'h0000, xbe_q} :
		hit_ybs ? {16'h0000, ybs_q} :
		hit_ybe ? {16'h0000, ybe_q} :
		hit_ccr ? {16'h0000, ccr_q} :
		hit_sta ? {16'h0000, status_w} : 32'h00000000;

	// answer one cycle after setup: no wait state beyond the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup & bad_access;
			prdata_q  <= (apb_setup & ~pwrite & ~bad_access) ? rd_mux : 32'h00000000;
		end
	end

	// register writes take effect at the completing edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amc_q <= `MBAG_RST_AMC;
			brc_q <= `MBAG_RST_16;
			tpg_q <= `MBAG_RST_8;
			vpg_q <= `MBAG_RST_8;
			xbs_q <= `MBAG_RST_16;
			xbe_q <= `MBAG_RST_16;
			ybs_q <= `MBAG_RST_16;
			ybe_q <= `MBAG_RST_16;
			ccr_q <= `MBAG_RST_16;
		end else if (apb_wr) begin
			if (hit_amc) amc_q <= pwdata[15:0];
			if (hit_brc) brc_q <= pwdata[15:0];
			if (hit_tpg) tpg_q <= pwdata[7:0];
			if (hit_vpg) vpg_q <= pwdata[7:0];
			if (hit_xbs) xbs_q <= pwdata[15:0];
			if (hit_xbe) xbe_q <= pwdata[15:0];
			if (hit_ybs) ybs_q <= pwdata[15:0];
			if (hit_ybe) ybe_q <= pwdata[15:0];
			if (hit_ccr) ccr_q <= pwdata[15:0];
		end
	end

	// ---------------- address generators ----------------
	// channel 0 reads x, channel 1 writes x, channel 2 serves y
	for (genvar ch = 0; ch < NCH; ch++) begin : g_agu
		mbag_agu_req_t rq;
		logic [15:0]   step;
		logic [15:0]   sum;
		logic [15:0]   mod_out;
		logic [15:0]   brev_sum;
		logic [15:0]   nxt;
		logic          inc_mode;
		logic          pre_mode;
		logic          post_mode;
		logic          brev_on;
		logic          mod_on;
		logic          wrap;

		assign rq        = agu_req[ch];
		assign inc_mode  = (rq.mode == am_pre_inc) | (rq.mode == am_post_inc);
		assign pre_mode  = (rq.mode == am_pre_inc) | (rq.mode == am_pre_dec);
		assign post_mode = (rq.mode == am_post_inc) | (rq.mode == am_post_dec);
		// decrements subtract the magnitude, indexed adds the signed offset
		assign step      = ((rq.mode == am_pre_dec) | (rq.mode == am_post_dec)) ? (16'h0000 - rq.ofs) :
		                   (rq.mode == am_ind) ? 16'h0000 : rq.ofs;
		assign sum       = rq.wval + step;

		// reversal lives in the x write generator alone, word writes only
		if (ch == CH_XW) begin : g_brev
			assign brev_on = brev_en & (rq.wsel == b_sel) & inc_mode & ~rq.byte_acc;
		end else begin : g_nobrev
			assign brev_on = 1'b0;
		end
		// pointer and modifier both in normal order, carry reversed; increment dropped
		assign brev_sum = mbag_rev_add(rq.wval, brev_mod) & 16'hfffe;

		// reversal outranks modulo in x write and y, x read keeps it
		if (ch == CH_Y) begin : g_ymod
			assign mod_on = y_mod_en & (rq.wsel == y_msel) & ~brev_en;
		end else if (ch == CH_XW) begin : g_xwmod
			assign mod_on = x_mod_en & (rq.wsel == x_msel) & ~brev_en;
		end else begin : g_xrmod
			assign mod_on = x_mod_en & (rq.wsel == x_msel);
		end

		mbag_modulo #(
			.W (16)
		) u_mod (
			.addr      (sum),
			.up        (~step[15]),
			.on        (mod_on),
			.buf_start ((ch == CH_Y) ? ybs_q : xbs_q),
			.buf_end   ((ch == CH_Y) ? ybe_q : xbe_q),
			.out_addr  (mod_out),
			.wrap      (wrap)
		);

		// y modulo addresses are word addresses
		if (ch == CH_Y) begin : g_yword
			assign nxt = brev_on ? brev_sum : (mod_on ? (mod_out & 16'hfffe) : mod_out);
		end else begin : g_xword
			assign nxt = brev_on ? brev_sum : mod_out;
		end

		// post modes address with the old pointer, pre and indexed with the new
		assign agu_rsp_d[ch].valid   = rq.valid;
		assign agu_rsp_d[ch].ea      = (post_mode | (rq.mode == am_ind)) ?
		                               (brev_on ? (rq.wval & 16'hfffe) : rq.wval) : nxt;
		// indexed modes are corrected but never write the pointer back
		assign agu_rsp_d[ch].wb_en   = rq.valid & (pre_mode | post_mode);
		assign agu_rsp_d[ch].wb_val  = nxt;
		assign agu_rsp_d[ch].wrapped = rq.valid & wrap & ~brev_on;
		assign agu_rsp_d[ch].brev    = rq.valid & brev_on;
		assign wrap_w[ch]            = agu_rsp_q[ch].wrapped;
	end

	assign brev_used = agu_rsp_q[CH_XW].brev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			agu_rsp_q <= '0;
		end else begin
			agu_rsp_q <= agu_rsp_d;
		end
	end

	// ---------------- program space addressing ----------------
	// table access: page on top of the full data address
	assign tbl_addr_d.valid = tbl_valid;
	assign tbl_addr_d.addr  = {tpg_q, tbl_ea};
	assign tbl_addr_d.cfg   = tpg_q[`MBAG_F_CFGSP];

	// the window only opens for an upper-half address with the enable set;
	// a table access in the same cycle owns the program bus, so it wins
	wire win_hit = win_req.valid & win_req.ea[`MBAG_F_EATOP] & win_en & ~tbl_valid;
	// data address bit 15 is dropped; page bit 0 lands in bit 15
	assign win_addr_d.valid = win_hit & ~win_req.write;
	assign win_addr_d.addr  = {1'b0, vpg_q, win_req.ea[14:0]};
	assign win_addr_d.cfg   = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_addr_q       <= '0;
			win_addr_q       <= '0;
			win_wr_refused_q <= 1'b0;
		end else begin
			tbl_addr_q       <= tbl_addr_d;
			win_addr_q       <= win_addr_d;
			win_wr_refused_q <= win_hit & win_req.write;
		end
	end

	// only the low word of the program word reaches data space;
	// the upper byte is never visible through the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_rvalid_q <= 1'b0;
			win_rdata_q  <= 16'h0000;
		end else begin
			win_rvalid_q <= prog_rvalid;
			win_rdata_q  <= prog_rvalid ? prog_rdata[15:0] : win_rdata_q;
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign agu_rsp        = agu_rsp_q;
	assign tbl_addr       = tbl_addr_q;
	assign win_addr       = win_addr_q;
	assign win_wr_refused = win_wr_refused_q;
	assign win_rvalid     = win_rvalid_q;
	assign win_rdata      = win_rdata_q;

endmodule : mbag_top

// ### mbag_sva.sv
`timescale 1ns/10ps
// port checker for the address generator top
module mbag_sva
	import mbag_pkg::*;
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire mbag_agu_req_t [2:0] agu_req,
	input wire mbag_agu_rsp_t [2:0] agu_rsp,
	input wire logic                tbl_valid,
	input wire logic [15:0]         tbl_ea,
	input wire mbag_prog_addr_t     tbl_addr,
	input wire mbag_win_req_t       win_req,
	input wire mbag_prog_addr_t     win_addr,
	input wire logic                prog_rvalid,
	input wire logic [23:0]         prog_rdata,
	input wire logic                win_rvalid,
	input wire logic [15:0]         win_rdata
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb setup then zero-wait access
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence
	property p_apb; s_setup |=> s_access; endproperty
	a_apb: assert property (p_apb) else $error("apb access not answered at once");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_tbl; tbl_valid |=> tbl_addr.valid && tbl_addr.addr[15:0] == $past(tbl_ea); endproperty
	a_tbl: assert property (p_tbl) else $error("table address low word wrong");
	property p_cfg; tbl_addr.valid |-> tbl_addr.cfg == tbl_addr.addr[23]; endproperty
	a_cfg: assert property (p_cfg) else $error("space flag not page msb");
	property p_user; win_addr.valid |-> !win_addr.addr[23] && !win_addr.cfg; endproperty
	a_user: assert property (p_user) else $error("window left user space");
	property p_ro; win_req.valid && win_req.write |=> !win_addr.valid; endproperty
	a_ro: assert property (p_ro) else $error("window write issued");
	property p_top; win_addr.valid |-> $past(win_req.ea[15]); endproperty
	a_top: assert property (p_top) else $error("window without top bit");
	property p_rd; prog_rvalid |=> win_rvalid && win_rdata == $past(prog_rdata[15:0]); endproperty
	a_rd: assert property (p_rd) else $error("window data not low word");
	property p_bch; !agu_rsp[0].brev && !agu_rsp[2].brev; endproperty
	a_bch: assert property (p_bch) else $error("reversal outside x write");
	property p_blsb; agu_rsp[1].brev |-> !agu_rsp[1].wb_val[0] && !agu_rsp[1].wrapped; endproperty
	a_blsb: assert property (p_blsb) else $error("reversed address bad");
	property p_wb;
		agu_rsp[0].wb_en |-> $past(agu_req[0].mode) inside {am_pre_inc, am_pre_dec, am_post_inc, am_post_dec};
	endproperty
	a_wb: assert property (p_wb) else $error("write back in wrong mode");
	property p_ylsb; agu_rsp[2].wrapped && agu_rsp[2].wb_en |-> !agu_rsp[2].wb_val[0]; endproperty
	a_ylsb: assert property (p_ylsb) else $error("y address lsb set");
endmodule : mbag_sva

// ### mbag_prog_mem.sv
`timescale 1ns/10ps
// program memory read port behind the window; lat adds wait cycles
module mbag_prog_mem
	import mbag_pkg::*;
(
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic [1:0]      lat,
	input wire mbag_prog_addr_t win_addr,
	output logic                prog_rvalid,
	output logic [23:0]         prog_rdata
);
	logic [23:0] addr_q;
	logic [2:0]  cnt_q;
	// word is a scramble of its address with a junk top byte, so dropping it is visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			addr_q <= 24'h000000;
			prog_rvalid <= 1'b0;
			prog_rdata <= 24'h000000;
		end else begin
			prog_rvalid <= 1'b0;
			prog_rdata <= ~prog_rdata; // idle bus never holds a word for two cycles
			if (win_addr.valid) begin
				addr_q <= win_addr.addr;
				cnt_q <= {1'b0, lat} + 3'h1;
			end else if (cnt_q == 3'h1) begin
				cnt_q <= 3'h0;
				prog_rvalid <= 1'b1;
				prog_rdata <= {8'hff, addr_q[15:0] ^ 16'h5a5a};
			end else if (cnt_q != 3'h0) begin
				cnt_q <= cnt_q - 3'h1;
			end
		end
	end
endmodule : mbag_prog_mem

// ### modulo_bitrev_address_gen_bench.sv
`timescale 1ns/10ps
`include "mbag_regs.svh"
module modulo_bitrev_address_gen_bench
	import mbag_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	mbag_agu_req_t [2:0] agu_req;
	mbag_agu_rsp_t [2:0] agu_rsp;
	logic tbl_valid, win_wr_refused, prog_rvalid, win_rvalid;
	logic [15:0] tbl_ea, win_rdata;
	mbag_prog_addr_t tbl_addr, win_addr;
	mbag_win_req_t win_req;
	logic [23:0] prog_rdata;
	logic [1:0] lat;
	int n_fail, tests_run, cyc;
	mbag_top mbag_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .agu_req, .agu_rsp, .tbl_valid, .tbl_ea, .tbl_addr, .win_req, .win_addr, .win_wr_refused,
		.prog_rvalid, .prog_rdata, .win_rvalid, .win_rdata);
	mbag_prog_mem mbag_prog_mem_inst (.pclk, .presetn, .lat, .win_addr, .prog_rvalid, .prog_rdata);
	task test_done();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, {31'h0, xe});
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	// one request on a generator; flags are valid, wb_en, wrapped, brev
	task agu(input int ch, input logic [3:0] s, input logic [15:0] v, input mbag_amode_t m, input logic [15:0] o,
		input logic b, input logic [15:0] xea, input logic [15:0] xwb, input logic [3:0] xf);
		@(posedge pclk);
		agu_req[ch] <= '{1'b1, s, v, m, o, b};
		@(posedge pclk);
		agu_req[ch].valid <= 1'b0;
		@(negedge pclk);
		chk({16'h0, agu_rsp[ch].ea}, {16'h0, xea});
		if (xf[2])
			chk({16'h0, agu_rsp[ch].wb_val}, {16'h0, xwb});
		chk({28'h0, agu_rsp[ch].valid, agu_rsp[ch].wb_en, agu_rsp[ch].wrapped, agu_rsp[ch].brev}, {28'h0, xf});
	endtask : agu
	// table or window access; x is {valid, addr, cfg}
	task prog(input logic t, input logic w, input logic [15:0] ea, input logic [25:0] x, input logic xr);
		@(posedge pclk);
		tbl_valid <= t;
		tbl_ea <= ea;
		win_req <= '{~t, w, ea};
		@(posedge pclk);
		tbl_valid <= 1'b0;
		win_req.valid <= 1'b0;
		@(negedge pclk);
		chk({6'h0, t ? tbl_addr : win_addr}, {6'h0, x});
		chk({31'h0, win_wr_refused}, {31'h0, xr});
		if (x[25] && !t) begin
			for (int i = 0; i < 8 && win_rvalid !== 1'b1; i++) @(negedge pclk);
			chk({31'h0, win_rvalid}, 32'h1);
			chk({16'h0, win_rdata}, {16'h0, x[16:1] ^ 16'h5a5a});
		end
	endtask : prog
	task t_regs();
		rd(`MBAG_OFS_AMC, 32'h0fff, 1'b0);
		rd(`MBAG_OFS_BRC, 32'h0, 1'b0);
		wr(`MBAG_OFS_TPG, 32'h1ff, 1'b0);
		rd(`MBAG_OFS_TPG, 32'hff, 1'b0);
		rd(8'h28, 32'h0, 1'b1);
		wr(`MBAG_OFS_STA, 32'h1, 1'b1);
	endtask : t_regs
	task t_mod();
		wr(`MBAG_OFS_XBS, 32'h1000, 1'b0);
		wr(`MBAG_OFS_XBE, 32'h100f, 1'b0);
		wr(`MBAG_OFS_AMC, 32'h8fff, 1'b0);
		agu(0, 4'h1, 16'h100e, am_post_inc, 16'h4, 1'b0, 16'h100e, 16'h1012, 4'hc);
		wr(`MBAG_OFS_AMC, 32'h8ff1, 1'b0);
		agu(0, 4'h1, 16'h100e, am_post_inc, 16'h4, 1'b0, 16'h100e, 16'h1002, 4'he);
		agu(0, 4'h1, 16'h1002, am_pre_dec, 16'h4, 1'b0, 16'h100e, 16'h100e, 4'he);
		agu(0, 4'h1, 16'h100e, am_reg_ofs, 16'h4, 1'b0, 16'h1002, 16'h0, 4'ha);
		agu(0, 4'h1, 16'h100e, am_ind, 16'h4, 1'b0, 16'h100e, 16'h0, 4'h8);
		agu(0, 4'h2, 16'h100e, am_post_inc, 16'h4, 1'b0, 16'h100e, 16'h1012, 4'hc);
		wr(`MBAG_OFS_YBS, 32'h2000, 1'b0);
		wr(`MBAG_OFS_YBE, 32'h200f, 1'b0);
		wr(`MBAG_OFS_AMC, 32'h4f1f, 1'b0);
		agu(2, 4'h1, 16'h200f, am_pre_inc, 16'h2, 1'b0, 16'h2000, 16'h2000, 4'he);
	endtask : t_mod
	task t_brev();
		wr(`MBAG_OFS_BRC, 32'h8008, 1'b0);
		wr(`MBAG_OFS_AMC, 32'h83f3, 1'b0);
		rd(`MBAG_OFS_STA, 32'h3, 1'b0);
		agu(1, 4'h3, 16'h0801, am_post_inc, 16'h2, 1'b0, 16'h0800, 16'h0810, 4'hd);
		agu(1, 4'h3, 16'h0810, am_pre_inc, 16'h2, 1'b0, 16'h0808, 16'h0808, 4'hd);
		agu(1, 4'h3, 16'h0810, am_post_inc, 16'h2, 1'b1, 16'h0810, 16'h0812, 4'hc);
		agu(1, 4'h3, 16'h0810, am_post_dec, 16'h2, 1'b0, 16'h0810, 16'h080e, 4'hc);
		agu(0, 4'h3, 16'h100e, am_post_inc, 16'h4, 1'b0, 16'h100e, 16'h1002, 4'he);
		agu(1, 4'h3, 16'h100e, am_post_inc, 16'h4, 1'b1, 16'h100e, 16'h1012, 4'hc);
		wr(`MBAG_OFS_BRC, 32'h0008, 1'b0);
		agu(1, 4'h3, 16'h0800, am_post_inc, 16'h2, 1'b0, 16'h0800, 16'h0802, 4'hc);
	endtask : t_brev
	task t_prog();
		wr(`MBAG_OFS_TPG, 32'h85, 1'b0);
		prog(1'b1, 1'b0, 16'h1234, {1'b1, 24'h851234, 1'b1}, 1'b0);
		wr(`MBAG_OFS_TPG, 32'h05, 1'b0);
		prog(1'b1, 1'b0, 16'hfedc, {1'b1, 24'h05fedc, 1'b0}, 1'b0);
		wr(`MBAG_OFS_VPG, 32'h03, 1'b0);
		wr(`MBAG_OFS_CCR, 32'h4, 1'b0);
		prog(1'b0, 1'b0, 16'h8abc, {1'b1, 24'h018abc, 1'b0}, 1'b0);
		wr(`MBAG_OFS_VPG, 32'h02, 1'b0);
		lat <= 2'h3;
		prog(1'b0, 1'b0, 16'hfffe, {1'b1, 24'h017ffe, 1'b0}, 1'b0);
		prog(1'b0, 1'b1, 16'h8abc, {1'b0, 24'h010abc, 1'b0}, 1'b1);
		prog(1'b0, 1'b0, 16'h1234, {1'b0, 24'h011234, 1'b0}, 1'b0);
		wr(`MBAG_OFS_CCR, 32'h0, 1'b0);
		prog(1'b0, 1'b0, 16'h8abc, {1'b0, 24'h010abc, 1'b0}, 1'b0);
	endtask : t_prog
	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// hang guard; the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, tbl_valid} = 5'h0;
		{paddr, pwdata, tbl_ea, lat} = '0;
		agu_req = '0;
		win_req = '0;
		{n_fail, tests_run, cyc} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_mod();
		t_brev();
		t_prog();
		test_done();
	end
endmodule : modulo_bitrev_address_gen_bench
bind mbag_top mbag_sva mbag_sva_inst (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .agu_req, .agu_rsp,
	.tbl_valid, .tbl_ea, .tbl_addr, .win_req, .win_addr, .prog_rvalid, .prog_rdata, .win_rvalid, .win_rdata);
